// ### logic/sysclk_consts.svh
// Purpose: constants for boot sequencing and system clock control
// Assumes: one 125 MHz clock domain
// Notes: slow rc and fast rc arrive as sampled levels
`ifndef SYSCLK_CONSTS_SVH
`define SYSCLK_CONSTS_SVH
`define BOOT_FAST_CYCLES 12'd47
`define BOOT_NORMAL_CYCLES 12'd2945
`define RESET_ENTRY_ADDR 11'h001
`define SYSTEM_ADDR 11'h000
`define IRQ_ENTRY_ADDR 11'h010
`define XTAL_EN_BIT 7
`define XTAL_DRIVE_HI 6
`define XTAL_DRIVE_LO 5
`define FAST_EN_BIT 4
`define SLOW_EN_BIT 2
`define MODE_FAST_DIV2 8'h34
`define MODE_FAST_DIV4 8'h14
`define MODE_FAST_DIV8 8'h3c
`define MODE_FAST_DIV16 8'h1c
`define MODE_FAST_DIV32 8'h7c
`define MODE_SLOW 8'he4
`define MODE_BOOT_FAST64 8'h94
`define MODE_BOOT_SLOW 8'hf4
`define TRIM_RESET 8'h80
`define XTAL_RESET 8'h00
`endif

// ### logic/sysclk_pkg.sv
// Purpose: types for boot sequencing and system clock control
// Assumes: constants live in sysclk_consts.svh
// Notes: none
package sysclk_pkg;
	typedef enum logic [1:0] {
		BOOT_WAIT = 2'b00,
		BOOT_CFG = 2'b01,
		BOOT_RUN = 2'b11
	} boot_e;
	typedef enum logic [2:0] {
		SRC_SLOW = 3'd0,
		SRC_XTAL = 3'd1,
		SRC_FAST = 3'd2,
		SRC_NONE = 3'd3
	} src_e;
	typedef struct packed {
		logic xtalEn;
		logic [1:0] xtalDrive;
		logic fastEn;
		logic slowEn;
		logic [7:0] fastTrim;
	} osc_s;
endpackage

// ### logic/clock_divider.sv
// Purpose: glitch-free clock-enable divider and source switch
// Assumes: source edges arrive as one-cycle pulses on the core clock
// Notes: ratio or source changes wait for a period boundary, except when leaving SRC_NONE, which takes them at once
`timescale 1ns/1ps
`default_nettype none
module clock_divider (
	input wire logic clock, // core clock
	input wire logic rstN, // synchronised reset
	input wire logic [2:0] srcSel, // requested source
	input wire logic [6:0] ratio, // divide ratio minus one
	input wire logic slowTick, // slow rc edge
	input wire logic fastTick, // fast rc edge
	input wire logic xtalTick, // crystal edge
	output logic sysTick // one tick per system clock period
);
	typedef struct packed {
		logic [2:0] src;
		logic [6:0] ratio;
		logic [6:0] cnt;
		logic tick;
		logic align;
	} st_s;
	st_s st_r, st_nxt;
	logic inTick;
	always_comb begin
		unique case (st_r.src)
			3'd0: inTick = slowTick;
			3'd1: inTick = xtalTick;
			3'd2: inTick = fastTick;
			default: inTick = 1'b0;
		endcase
		st_nxt = st_r;
		st_nxt.tick = 1'b0;
		if (inTick) begin
			if (st_r.align) begin
				// first edge of a new source only restarts the count
				st_nxt.align = 1'b0;
				st_nxt.cnt = 7'h00;
			end else if (st_r.cnt >= st_r.ratio) begin
				st_nxt.cnt = 7'h00;
				st_nxt.tick = 1'b1;
				// switch only at a boundary: no short period
				st_nxt.src = srcSel;
				st_nxt.ratio = ratio;
				st_nxt.align = (srcSel != st_r.src);
			end else begin
				st_nxt.cnt = st_r.cnt + 7'h01;
			end
		end
		if (st_r.src == 3'd3) begin
			st_nxt.src = srcSel;
			st_nxt.ratio = ratio;
		end
	end
	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign sysTick = st_r.tick;
	chk_count_bound: assert property (@(posedge clock) disable iff (!rstN)
		st_r.cnt <= st_r.ratio)
		else $error("divider count beyond ratio");
endmodule // clock_divider
`default_nettype wire

// ### logic/system_clock_boot_control.sv
// Purpose: power-on boot delay, entry vectors, oscillator enables, clock mode
// Assumes: oscillator outputs are asynchronous levels, synced here
// Notes: control bits are plain ports written by the core
`timescale 1ns/1ps
`default_nettype none
`include "sysclk_consts.svh"
// Notes on behaviour
// - core held in reset 47 slow cycles fast boot, 2945 normal boot.
// - after reset, fetch starts at 0x001; 0x000 is reserved.
// - a taken interrupt redirects fetch to 0x10.
// - crystal enabled by bit 7; fast rc bit 4, slow rc bit 2.
// - after boot slow rc runs; fast rc runs unless a calibrated mode clears bit 4.
// - fast rc frequency is set by a trim register.
// - mode 34h, 14h, 3Ch give fast rc over 2, 4, 8.
// - mode 1Ch, 7Ch give fast rc over 16, 32; E4h gives slow rc.
// - without calibration, mode and trim keep their boot defaults.
// - calibrated boot: watchdog off, slow rc on, port a bit five input.
// - uncalibrated boot: slow rc or fast rc over 64, watchdog on.
// - mode write switches source at the next period boundary; oscillator enables follow the new mode at once.
// - crystal bits 6:5 select low, middle or high drive.
module system_clock_boot_control (
	input wire logic clock, // 125 MHz core clock
	input wire logic rst_n, // power-on reset, active low
	input wire logic slowRcIn, // slow_rc_oscillator output
	input wire logic fastRcIn, // fast_rc_oscillator output
	input wire logic xtalIn, // crystal_oscillator output
	input wire logic fastBoot, // boot time option: fast
	input wire logic trimDirective, // trim_directive applied at boot
	input wire logic [7:0] trimMode, // mode chosen by trim_directive
	input wire logic [7:0] trimValue, // calibrated trim value
	input wire logic bootSlowClk, // uncalibrated boot uses slow rc
	input wire logic modeWr, // write strobe, clock mode
	input wire logic xtalWr, // write strobe, crystal control
	input wire logic trimWr, // write strobe, fast rc trim
	input wire logic [7:0] wrData, // write data
	input wire logic irqTake, // interrupt taken this cycle
	output logic coreRstN, // core reset, active low
	output logic fetchLoad, // load fetch address pulse
	output logic [10:0] fetchAddr, // fetch address
	output logic [7:0] clockMode, // clock-mode register
	output logic [7:0] xtalCtrl, // crystal control register
	output var sysclk_pkg::osc_s osc, // oscillator controls
	output logic watchdogEn, // watchdog enable
	output logic portABitFiveIn, // port_a_bit_five input mode
	output logic sysTick // system clock enable tick
);
	typedef struct packed {
		logic [1:0] rst;
		logic [1:0] slowS;
		logic [1:0] fastS;
		logic [1:0] xtalS;
		logic slowD;
		logic fastD;
		logic xtalD;
		sysclk_pkg::boot_e boot;
		logic [11:0] cnt;
		logic [7:0] mode;
		logic [7:0] xtal;
		logic [7:0] trim;
		logic wdt;
		logic load;
		logic [10:0] addr;
	} st_s;
	st_s st_r, st_nxt;
	logic rstSync;
	logic slowTick, fastTick, xtalTick;
	logic [2:0] srcSel;
	logic [6:0] ratio;

	// map a clock-mode value to source and ratio minus one
	function automatic logic [9:0] decode(input logic [7:0] m);
		unique case (m)
			`MODE_FAST_DIV2: decode = {3'd2, 7'd1};
			`MODE_FAST_DIV4: decode = {3'd2, 7'd3};
			`MODE_FAST_DIV8: decode = {3'd2, 7'd7};
			`MODE_FAST_DIV16: decode = {3'd2, 7'd15};
			`MODE_FAST_DIV32: decode = {3'd2, 7'd31};
			`MODE_SLOW, `MODE_BOOT_SLOW: decode = {3'd0, 7'd0};
			`MODE_BOOT_FAST64: decode = {3'd2, 7'd63};
			default: decode = {3'd1, 7'd0};
		endcase
	endfunction

	assign rstSync = st_r.rst[1];
	assign slowTick = st_r.slowS[1] & ~st_r.slowD;
	assign fastTick = st_r.fastS[1] & ~st_r.fastD;
	assign xtalTick = st_r.xtalS[1] & ~st_r.xtalD;
	assign {srcSel, ratio} = decode(st_r.mode);

	always_comb begin
		st_nxt = st_r;
		st_nxt.rst = {st_r.rst[0], 1'b1};
		st_nxt.slowS = {st_r.slowS[0], slowRcIn};
		st_nxt.fastS = {st_r.fastS[0], fastRcIn};
		st_nxt.xtalS = {st_r.xtalS[0], xtalIn};
		st_nxt.slowD = st_r.slowS[1];
		st_nxt.fastD = st_r.fastS[1];
		st_nxt.xtalD = st_r.xtalS[1];
		st_nxt.load = 1'b0;
		unique case (st_r.boot)
			sysclk_pkg::BOOT_WAIT: begin
				if (slowTick) begin
					st_nxt.cnt = st_r.cnt + 12'h001;
				end
				if (st_r.cnt >= (fastBoot ? `BOOT_FAST_CYCLES
						: `BOOT_NORMAL_CYCLES)) begin
					st_nxt.boot = sysclk_pkg::BOOT_CFG;
				end
			end
			sysclk_pkg::BOOT_CFG: begin
				if (trimDirective) begin
					st_nxt.mode = trimMode;
					st_nxt.trim = trimValue;
					st_nxt.wdt = 1'b0;
					st_nxt.mode[`SLOW_EN_BIT] = 1'b1;
				end else begin
					st_nxt.mode = bootSlowClk ? `MODE_BOOT_SLOW
						: `MODE_BOOT_FAST64;
					st_nxt.wdt = 1'b1;
				end
				st_nxt.load = 1'b1;
				st_nxt.addr = `RESET_ENTRY_ADDR;
				st_nxt.boot = sysclk_pkg::BOOT_RUN;
			end
			sysclk_pkg::BOOT_RUN: begin
				if (modeWr) begin
					st_nxt.mode = wrData;
				end
				if (xtalWr) begin
					st_nxt.xtal = wrData;
				end
				if (trimWr) begin
					st_nxt.trim = wrData;
				end
				if (irqTake) begin
					st_nxt.load = 1'b1;
					st_nxt.addr = `IRQ_ENTRY_ADDR;
				end
			end
			default: st_nxt.boot = sysclk_pkg::BOOT_WAIT;
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
			st_r.boot <= sysclk_pkg::BOOT_WAIT;
			st_r.mode <= `MODE_BOOT_SLOW;
			st_r.trim <= `TRIM_RESET;
			st_r.xtal <= `XTAL_RESET;
			st_r.addr <= `SYSTEM_ADDR;
			st_r.wdt <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	clock_divider divider (
		.clock(clock),
		.rstN(rstSync),
		.srcSel(srcSel),
		.ratio(ratio),
		.slowTick(slowTick),
		.fastTick(fastTick),
		.xtalTick(xtalTick),
		.sysTick(sysTick)
	);

	assign coreRstN = (st_r.boot == sysclk_pkg::BOOT_RUN);
	assign fetchLoad = st_r.load;
	assign fetchAddr = st_r.addr;
	assign clockMode = st_r.mode;
	assign xtalCtrl = st_r.xtal;
	assign osc = {
		st_r.xtal[`XTAL_EN_BIT],
		st_r.xtal[`XTAL_DRIVE_HI:`XTAL_DRIVE_LO],
		st_r.mode[`FAST_EN_BIT],
		st_r.mode[`SLOW_EN_BIT],
		st_r.trim
	};
	assign watchdogEn = st_r.wdt;
	assign portABitFiveIn = 1'b1;

	chk_entry_addr: assert property (@(posedge clock) disable iff (!rst_n)
		$rose(coreRstN) |-> fetchLoad && fetchAddr == 11'h001)
		else $error("reset entry not 0x001");
	chk_irq_vector: assert property (@(posedge clock) disable iff (!rst_n)
		coreRstN && irqTake |=> fetchLoad && fetchAddr == 11'h010)
		else $error("interrupt entry not 0x10");
	chk_boot_fast: assert property (@(posedge clock) disable iff (!rst_n)
		$rose(coreRstN) && fastBoot |-> st_r.cnt >= 12'd47)
		else $error("fast boot released early");
	chk_boot_normal: assert property (@(posedge clock) disable iff (!rst_n)
		$rose(coreRstN) && !fastBoot |-> st_r.cnt >= 12'd2945)
		else $error("normal boot released early");
	chk_boot_osc: assert property (@(posedge clock) disable iff (!rst_n)
		$rose(coreRstN) && !trimDirective |-> osc.slowEn)
		else $error("slow rc off after boot");
	chk_cal_wdt: assert property (@(posedge clock) disable iff (!rst_n)
		$rose(coreRstN) |-> watchdogEn == !$past(trimDirective))
		else $error("watchdog state wrong after boot");
	chk_mode_write: assert property (@(posedge clock) disable iff (!rst_n)
		coreRstN && modeWr |=> clockMode == $past(wrData))
		else $error("clock mode write lost");
	chk_drive_bits: assert property (@(posedge clock) disable iff (!rst_n)
		coreRstN && xtalWr |=> osc.xtalDrive == $past(wrData[6:5]))
		else $error("crystal drive wrong");
	chk_trim_write: assert property (@(posedge clock) disable iff (!rst_n)
		coreRstN && trimWr |=> osc.fastTrim == $past(wrData))
		else $error("trim write lost");
	cov_fast_boot: cover property (@(posedge clock) $rose(coreRstN) && fastBoot);
	cov_cal_boot: cover property (@(posedge clock)
		$rose(coreRstN) && trimDirective);
	cov_irq: cover property (@(posedge clock) fetchLoad && fetchAddr == 11'h010);
	cov_switch: cover property (@(posedge clock) modeWr && wrData == 8'h34);
endmodule // system_clock_boot_control
`default_nettype wire

// ### sim/tb.sv
// Purpose: self-checking bench for boot sequencing and clock control
// Assumes: oscillators are free-running levels made here
// Notes: inputs change on the falling clock edge
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clock, rst_n, slowRcIn, fastRcIn, xtalIn, fastBoot, trimDirective;
	logic bootSlowClk, modeWr, xtalWr, trimWr, irqTake;
	logic coreRstN, fetchLoad, watchdogEn, portABitFiveIn, sysTick;
	logic [7:0] trimMode, trimValue, wrData, clockMode, xtalCtrl;
	logic [10:0] fetchAddr;
	sysclk_pkg::osc_s osc;
	int nMismatch = 0;
	int samplesChecked = 0;
	int p, prevP, lo;
	logic [7:0] modes [6] = '{8'h34, 8'h14, 8'h3c, 8'h1c, 8'h7c, 8'he4};
	int pers [6] = '{8, 16, 32, 64, 128, 6};
	system_clock_boot_control DUT (.clock(clock), .rst_n(rst_n),
		.slowRcIn(slowRcIn), .fastRcIn(fastRcIn), .xtalIn(xtalIn),
		.fastBoot(fastBoot), .trimDirective(trimDirective),
		.trimMode(trimMode), .trimValue(trimValue), .bootSlowClk(bootSlowClk),
		.modeWr(modeWr), .xtalWr(xtalWr), .trimWr(trimWr), .wrData(wrData),
		.irqTake(irqTake), .coreRstN(coreRstN), .fetchLoad(fetchLoad),
		.fetchAddr(fetchAddr), .clockMode(clockMode), .xtalCtrl(xtalCtrl),
		.osc(osc), .watchdogEn(watchdogEn), .portABitFiveIn(portABitFiveIn),
		.sysTick(sysTick));
	initial clock = 1'b0;
	always #4 clock = ~clock;
	// slow rc 6 cycles, fast rc 4, crystal 8; edges kept off posedge
	always #24 slowRcIn = ~slowRcIn;
	always #16 fastRcIn = ~fastRcIn;
	always #32 xtalIn = ~xtalIn;
	task closeOut;
		$display("checks %0d mismatches %0d", samplesChecked, nMismatch);
		if (nMismatch == 0 && samplesChecked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chkv(input string nm, input logic [10:0] exp, input logic [10:0] got);
		samplesChecked++;
		if (got !== exp) begin
			nMismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task chkr(input string nm, input int mn, input int mx, input int got);
		samplesChecked++;
		if (got < mn || got > mx) begin
			nMismatch++;
			$display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, mn, mx, got);
		end
	endtask
	task wr(input logic [2:0] sel, input logic [7:0] d);
		{modeWr, xtalWr, trimWr} = sel;
		wrData = d;
		@(negedge clock);
		{modeWr, xtalWr, trimWr} = 3'b000;
		@(negedge clock);
	endtask
	task period(output int n);
		int i;
		i = 0;
		@(negedge clock);
		while (sysTick !== 1'b1 && i < 1000) begin
			@(negedge clock);
			i++;
		end
		n = 0;
		do begin
			@(negedge clock);
			n++;
		end while (sysTick !== 1'b1 && n < 1000);
	endtask
	task boot(input logic fb, td, bs, input logic [7:0] tm, tv, input int n);
		int c;
		c = 0;
		rst_n = 1'b0;
		{fastBoot, trimDirective, bootSlowClk} = {fb, td, bs};
		{trimMode, trimValue} = {tm, tv};
		repeat (3) @(negedge clock);
		rst_n = 1'b1;
		@(negedge clock);
		wr(3'b100, 8'h1c);
		while (coreRstN !== 1'b1 && c < 20000) begin
			@(negedge clock);
			c++;
		end
		chkr("bootDelay", n * 6 - 8, n * 6 + 10, c + 2);
		chkv("fetchLoad", 11'h1, 11'(fetchLoad));
		chkv("fetchAddr", 11'h001, fetchAddr);
		chkv("fastEn", 11'h1, 11'(osc.fastEn));
		chkv("slowEn", 11'h1, 11'(osc.slowEn));
		chkv("portIn", 11'h1, 11'(portABitFiveIn));
	endtask
	initial begin
		{rst_n, slowRcIn, fastRcIn, xtalIn, irqTake} = 5'h00;
		{modeWr, xtalWr, trimWr, wrData} = 11'h000;
		boot(1'b1, 1'b0, 1'b1, 8'h00, 8'h00, 47);
		chkv("mode", 11'hf4, 11'(clockMode));
		chkv("trim", 11'h80, 11'(osc.fastTrim));
		chkv("wdog", 11'h1, 11'(watchdogEn));
		period(p);
		period(p);
		chkr("slowPeriod", 6, 6, p);
		$display("test uncalibrated fast boot done");
		boot(1'b1, 1'b1, 1'b0, 8'h3c, 8'h5a, 47);
		chkv("mode", 11'h03c, 11'(clockMode));
		chkv("trim", 11'h05a, 11'(osc.fastTrim));
		chkv("wdog", 11'h0, 11'(watchdogEn));
		irqTake = 1'b1;
		@(negedge clock);
		irqTake = 1'b0;
		chkv("irqLoad", 11'h1, 11'(fetchLoad));
		chkv("irqAddr", 11'h010, fetchAddr);
		$display("test calibrated boot and interrupt done");
		prevP = 32;
		for (int i = 0; i < 6; i++) begin
			wr(3'b100, modes[i]);
			chkv("mode", 11'(modes[i]), 11'(clockMode));
			chkv("fastEn", 11'(modes[i][4]), 11'(osc.fastEn));
			chkv("slowEn", 11'(modes[i][2]), 11'(osc.slowEn));
			lo = pers[i] < prevP ? pers[i] : prevP;
			period(p);
			chkr("switchGap", lo, 1000, p);
			period(p);
			period(p);
			chkr("divPeriod", pers[i], pers[i], p);
			prevP = pers[i];
		end
		$display("test clock modes done");
		for (int d = 1; d < 4; d++) begin
			wr(3'b010, {1'b1, 2'(d), 5'h00});
			chkv("drive", 11'(d), 11'(osc.xtalDrive));
			chkv("xtalEn", 11'h1, 11'(osc.xtalEn));
		end
		wr(3'b010, 8'h00);
		chkv("xtalEn", 11'h0, 11'(osc.xtalEn));
		wr(3'b001, 8'h33);
		chkv("trim", 11'h033, 11'(osc.fastTrim));
		$display("test crystal and trim done");
		boot(1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 2945);
		chkv("mode", 11'h094, 11'(clockMode));
		chkv("wdog", 11'h1, 11'(watchdogEn));
		period(p);
		period(p);
		chkr("fast64Period", 256, 256, p);
		$display("test normal boot done");
		closeOut();
	end
	initial begin
		#(60000 * 8);
		nMismatch++;
		$display("watchdog expired");
		closeOut();
	end
endmodule // tb
`default_nettype wire
